// File: rtl/ads_pkg.sv
// Shared constants and carrier types for the accumulator display sequencer
package ads_pkg;

    // Timing divider and step counter shape
    localparam int TIMER_WIDTH = 24;
    localparam int STEP_WIDTH = 4;
    localparam int TAP_STROBE_LOW = 6;
    localparam int TAP_STROBE_HIGH = 7;
    localparam int TAP_STEP = 8;

    // Upper table address bits driven by the display request (table addresses 060-077 octal)
    localparam logic [3:0] ACC_PROGRAM_PAGE = 4'h3;

    // Table words of the accumulator display program, indexed by step
    localparam logic [7:0] WORD_DRIVE_TABLE = 8'h0B;
    localparam logic [7:0] WORD_OUTPUT_OPCODE = 8'hD3;
    localparam logic [7:0] WORD_PANEL_PORT = 8'hFF;
    localparam logic [7:0] WORD_RELEASE_ONLY = 8'h01;
    localparam logic [7:0] WORD_JUMP_OPCODE = 8'hC3;
    localparam logic [7:0] WORD_DRIVE_LOW_ADDR = 8'h23;
    localparam logic [7:0] WORD_DRIVE_HIGH_ADDR = 8'h13;
    localparam logic [7:0] WORD_CLEAR = 8'h00;
    localparam logic [7:0] WORD_TERMINATOR = 8'h7F;
    localparam logic [7:0] ACC_PROGRAM [0:15] = '{
        WORD_DRIVE_TABLE, WORD_OUTPUT_OPCODE, WORD_DRIVE_TABLE, WORD_PANEL_PORT,
        WORD_RELEASE_ONLY, WORD_CLEAR, WORD_DRIVE_TABLE, WORD_JUMP_OPCODE,
        WORD_DRIVE_LOW_ADDR, WORD_CLEAR, WORD_DRIVE_HIGH_ADDR, WORD_CLEAR,
        WORD_CLEAR, WORD_TERMINATOR, WORD_TERMINATOR, WORD_TERMINATOR};

    // Control latch output positions (output n sits at bit 8-n)
    localparam int CTRL_ARM_B = 0;
    localparam int CTRL_ARM_A = 1;
    localparam int CTRL_DRIVE_TABLE = 3;
    localparam int CTRL_DRIVE_HIGH = 4;
    localparam int CTRL_DRIVE_LOW = 5;

    // Front-panel output port number
    localparam logic [7:0] PANEL_PORT = 8'hFF;
    localparam logic [7:0] IDLE_DATA_LINES = 8'hFF;

    // APB register map
    localparam int APB_ADDR_WIDTH = 8;
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SAVED_ADDRESS = 8'h08;
    localparam logic [7:0] REG_LAMPS = 8'h0C;
    localparam int CONTROL_START_BIT = 0;
    localparam int CONTROL_TIMER_ENABLE_BIT = 1;
    localparam logic CONTROL_TIMER_ENABLE_RESET = 1'b1;

    typedef enum logic [1:0] {
        PHASE_IDLE = 2'b00,
        PHASE_STARTING = 2'b01,
        PHASE_STEPPING = 2'b10
    } ads_phase_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [APB_ADDR_WIDTH-1:0] paddr;
        logic [31:0] pwdata;
    } ads_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ads_apb_rsp_type;

    typedef struct packed {
        logic [15:0] programAddress;
        logic [15:0] address;
        logic [7:0] dataOut;
        logic [7:0] memoryData;
        logic cycleSync;
        logic statusDataOut5N;
        logic dataInStrobe;
        logic outputStatus;
        logic writeStrobe;
    } ads_cpu_in_type;

    typedef struct packed {
        logic ready;
        logic [7:0] dataIn;
        logic dataInEnable;
    } ads_cpu_out_type;

    typedef struct packed {
        logic [15:0] zero;
        logic [7:0] controlLatch;
        logic [3:0] step;
        logic pad;
        logic run;
        logic [1:0] phase;
    } ads_status_type;

endpackage

// File: rtl/ads_sequencer.sv
// Accumulator display sequencer: table program that forces bytes into a halted processor
`timescale 1ns/1ps
`default_nettype none

module ads_sequencer #(
    parameter int TIMER_WIDTH = ads_pkg::TIMER_WIDTH
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire ads_pkg::ads_apb_req_type apbReq,
    output var ads_pkg::ads_apb_rsp_type apbRsp,
    input wire logic accShowRequest,
    input wire ads_pkg::ads_cpu_in_type cpuIn,
    output var ads_pkg::ads_cpu_out_type cpuOut,
    output logic [7:0] forcedDataInN,
    output logic [7:0] tableAddress,
    output logic [7:0] tableData,
    output logic accShowActiveN,
    output logic displayLatchMode,
    output logic displayLatchStrobe,
    output logic [7:0] displayLamps,
    output logic singleCycleReleaseN,
    output logic forcedInputGateN,
    output logic panelReadyN,
    output logic stepCounterClearN,
    output logic addressSaveStrobe
);

    // Refuse a divider too short to carry the step tap
    if (TIMER_WIDTH <= ads_pkg::TAP_STEP) begin : gTimerCheck
        $error("TIMER_WIDTH must exceed the step tap position");
    end

    // Refuse taps that cannot form a strobe window ahead of the step tap
    if (ads_pkg::TAP_STROBE_LOW >= ads_pkg::TAP_STROBE_HIGH
        || ads_pkg::TAP_STROBE_HIGH >= ads_pkg::TAP_STEP) begin : gTapCheck
        $error("strobe taps must sit below the step tap");
    end

    // Refuse a step counter that does not span the program table
    if ((1 << ads_pkg::STEP_WIDTH) != $size(ads_pkg::ACC_PROGRAM)) begin : gTableCheck
        $error("step counter must span the program table");
    end

    typedef struct packed {
        ads_pkg::ads_phase_type phase;
        logic [TIMER_WIDTH-1:0] timer;
        logic tap8Prev;
        logic switchPrev;
        logic startLatch;
        logic [ads_pkg::STEP_WIDTH-1:0] step;
        logic stepWorked;
        logic [7:0] controlLatch;
        logic [15:0] savedAddress;
        logic run;
        logic timerEnable;
        logic apbReady;
        logic apbError;
        logic [31:0] apbData;
        logic cpuReady;
        logic readyN;
        logic [7:0] cpuDataIn;
        logic cpuDataInEnable;
        logic [7:0] forcedN;
        logic [7:0] tableAddr;
        logic [7:0] tableWord;
        logic activeN;
        logic mode;
        logic dispStrobe;
        logic [7:0] lamps;
        logic releaseN;
        logic gateN;
        logic clearN;
        logic saveStrobe;
    } ads_state_type;

    ads_state_type r;
    ads_state_type s;

    // Table lookup: only the accumulator display page holds a program
    function automatic logic [7:0] readTable(input logic [7:0] addr);
        if (addr[7:4] == ads_pkg::ACC_PROGRAM_PAGE) begin
            readTable = ads_pkg::ACC_PROGRAM[addr[3:0]];
        end else begin
            readTable = ads_pkg::WORD_CLEAR;
        end
    endfunction

    // Byte put on the forced data lines by the enabled drivers
    function automatic logic [7:0] forcedByte(input logic [7:0] ctrl, input logic [7:0] word,
                                              input logic [15:0] saved);
        if (ctrl[ads_pkg::CTRL_DRIVE_TABLE]) begin
            forcedByte = word;
        end else if (ctrl[ads_pkg::CTRL_DRIVE_LOW]) begin
            forcedByte = saved[7:0];
        end else if (ctrl[ads_pkg::CTRL_DRIVE_HIGH]) begin
            forcedByte = saved[15:8];
        end else begin
            forcedByte = ads_pkg::WORD_CLEAR;
        end
    endfunction

    // True when any forced-data driver is enabled
    function automatic logic driversOn(input logic [7:0] ctrl);
        driversOn = ctrl[ads_pkg::CTRL_DRIVE_TABLE] | ctrl[ads_pkg::CTRL_DRIVE_LOW]
            | ctrl[ads_pkg::CTRL_DRIVE_HIGH];
    endfunction

    // Next-state logic
    always_comb begin
        logic tap6;
        logic tap7;
        logic tap8;
        logic strobe;
        logic stepClock;
        logic access;
        logic commit;
        logic swStart;
        logic press;
        logic odd;
        logic [7:0] word;
        logic [7:0] nextAddr;
        logic panelWrite;
        logic gateOn;
        ads_pkg::ads_status_type status;
        tap6 = 1'b0;
        tap7 = 1'b0;
        tap8 = 1'b0;
        strobe = 1'b0;
        stepClock = 1'b0;
        access = 1'b0;
        commit = 1'b0;
        swStart = 1'b0;
        press = 1'b0;
        odd = 1'b0;
        word = '0;
        nextAddr = '0;
        panelWrite = 1'b0;
        gateOn = 1'b0;
        status = '0;
        s = r;

        // Free-running divider and its taps
        if (r.timerEnable) begin
            s.timer = r.timer + 1'b1;
        end
        tap6 = r.timer[ads_pkg::TAP_STROBE_LOW];
        tap7 = r.timer[ads_pkg::TAP_STROBE_HIGH];
        tap8 = r.timer[ads_pkg::TAP_STEP];
        strobe = tap6 & tap7 & ~tap8;
        stepClock = tap8 & ~r.tap8Prev;
        s.tap8Prev = tap8;

        // APB slave: one wait state, then answer with pready
        access = apbReq.psel & apbReq.penable & ~r.apbReady;
        s.apbReady = access;
        s.apbError = 1'b0;
        status.controlLatch = r.controlLatch;
        status.step = r.step;
        status.run = r.run;
        status.phase = r.phase;
        if (access) begin
            s.apbData = '0;
            case (apbReq.paddr)
                ads_pkg::REG_CONTROL: begin
                    s.apbData[ads_pkg::CONTROL_TIMER_ENABLE_BIT] = r.timerEnable;
                end
                ads_pkg::REG_STATUS: begin
                    s.apbData = status;
                end
                ads_pkg::REG_SAVED_ADDRESS: begin
                    s.apbData[15:0] = r.savedAddress;
                end
                ads_pkg::REG_LAMPS: begin
                    s.apbData[7:0] = r.lamps;
                end
                default: begin
                    s.apbError = 1'b1;
                end
            endcase
        end

        // Control write lands only at the completing edge, while pready stands high,
        // so a transfer that the master abandons early never starts the sequence
        commit = r.apbReady & apbReq.psel & apbReq.penable & apbReq.pwrite;
        if (commit && (apbReq.paddr == ads_pkg::REG_CONTROL)) begin
            s.timerEnable = apbReq.pwdata[ads_pkg::CONTROL_TIMER_ENABLE_BIT];
            swStart = apbReq.pwdata[ads_pkg::CONTROL_START_BIT];
        end

        // Sequencer
        press = (accShowRequest & ~r.switchPrev) | swStart;
        s.switchPrev = accShowRequest;
        odd = r.step[0];
        word = readTable({ads_pkg::ACC_PROGRAM_PAGE, r.step});
        case (r.phase)
            ads_pkg::PHASE_IDLE: begin
                if (press) begin
                    s.phase = ads_pkg::PHASE_STARTING;
                    s.startLatch = 1'b1;
                    s.step = '0;
                    s.savedAddress = cpuIn.programAddress;
                    s.controlLatch = ads_pkg::WORD_CLEAR;
                    s.stepWorked = 1'b0;
                    s.run = 1'b0;
                end
            end
            ads_pkg::PHASE_STARTING: begin
                s.step = '0;
                if (!tap6) begin
                    s.startLatch = 1'b0;
                    s.phase = ads_pkg::PHASE_STEPPING;
                end
            end
            ads_pkg::PHASE_STEPPING: begin
                if (word == ads_pkg::WORD_TERMINATOR) begin
                    s.phase = ads_pkg::PHASE_IDLE;
                end else begin
                    // Even step loads the control word, odd step keeps it
                    if (strobe && !odd) begin
                        s.controlLatch = word;
                        s.stepWorked = 1'b1;
                    end
                    // Armed odd step: release the processor once
                    if (strobe && odd && !r.stepWorked) begin
                        s.stepWorked = 1'b1;
                        if (r.controlLatch[ads_pkg::CTRL_ARM_B]) begin
                            s.run = 1'b1;
                        end
                    end else if (r.run && cpuIn.cycleSync && !cpuIn.statusDataOut5N) begin
                        s.run = 1'b0;
                    end
                    // Advance only after the step's work and with the processor halted
                    if (stepClock && r.stepWorked && !r.run) begin
                        s.step = r.step + 1'b1;
                        s.stepWorked = 1'b0;
                    end
                end
            end
            default: begin
                s.phase = ads_pkg::PHASE_IDLE;
            end
        endcase

        // Release strobe and forced-input gate of an armed odd step
        // Gate stays open while run so a read that outlasts the window completes
        s.releaseN = ~((r.phase == ads_pkg::PHASE_STEPPING) & odd & strobe
            & r.controlLatch[ads_pkg::CTRL_ARM_B]);
        gateOn = (s.phase == ads_pkg::PHASE_STEPPING) & s.step[0]
            & s.controlLatch[ads_pkg::CTRL_ARM_A] & (strobe | s.run);
        s.gateN = ~gateOn;

        // Table view and forced data lines
        nextAddr = {ads_pkg::ACC_PROGRAM_PAGE, s.step};
        s.tableAddr = nextAddr;
        s.tableWord = readTable(nextAddr);
        if (driversOn(s.controlLatch)) begin
            s.forcedN = ~forcedByte(s.controlLatch, s.tableWord, s.savedAddress);
        end else begin
            s.forcedN = ads_pkg::IDLE_DATA_LINES;
        end

        // Processor side: data input driven only while gated and read strobed
        s.cpuReady = s.run;
        s.readyN = ~s.run;
        s.cpuDataIn = forcedByte(s.controlLatch, s.tableWord, s.savedAddress);
        s.cpuDataInEnable = gateOn & cpuIn.dataInStrobe
            & driversOn(s.controlLatch);

        // Start latch outputs and active indication
        s.clearN = ~s.startLatch;
        s.saveStrobe = s.startLatch;
        s.activeN = (s.phase == ads_pkg::PHASE_IDLE);
        s.mode = s.activeN;

        // Display latch: panel port writes always, memory reads only in mode high
        panelWrite = (cpuIn.address[7:0] == ads_pkg::PANEL_PORT) & cpuIn.outputStatus
            & cpuIn.writeStrobe;
        s.dispStrobe = panelWrite | (r.mode & cpuIn.dataInStrobe);
        if (panelWrite) begin
            s.lamps = cpuIn.dataOut;
        end else if (r.mode && cpuIn.dataInStrobe) begin
            s.lamps = cpuIn.memoryData;
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.phase <= ads_pkg::PHASE_IDLE;
            r.timerEnable <= ads_pkg::CONTROL_TIMER_ENABLE_RESET;
            r.forcedN <= ads_pkg::IDLE_DATA_LINES;
            r.activeN <= 1'b1;
            r.mode <= 1'b1;
            r.releaseN <= 1'b1;
            r.gateN <= 1'b1;
            r.clearN <= 1'b1;
            r.readyN <= 1'b1;
        end else begin
            r <= s;
        end
    end

    // Outputs straight from the state register
    assign apbRsp.prdata = r.apbData;
    assign apbRsp.pready = r.apbReady;
    assign apbRsp.pslverr = r.apbError;
    assign cpuOut.ready = r.cpuReady;
    assign cpuOut.dataIn = r.cpuDataIn;
    assign cpuOut.dataInEnable = r.cpuDataInEnable;
    assign forcedDataInN = r.forcedN;
    assign tableAddress = r.tableAddr;
    assign tableData = r.tableWord;
    assign accShowActiveN = r.activeN;
    assign displayLatchMode = r.mode;
    assign displayLatchStrobe = r.dispStrobe;
    assign displayLamps = r.lamps;
    assign singleCycleReleaseN = r.releaseN;
    assign forcedInputGateN = r.gateN;
    assign panelReadyN = r.readyN;
    assign stepCounterClearN = r.clearN;
    assign addressSaveStrobe = r.saveStrobe;

endmodule

`default_nettype wire

// File: test/ads_sequencer_props.sv
// Port checks for the accumulator display sequencer
`timescale 1ns/1ps
`default_nettype none
module ads_sequencer_props #(
    parameter int TIMER_WIDTH = 24
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic accShowRequest,
    input wire ads_pkg::ads_cpu_in_type cpuIn,
    input wire ads_pkg::ads_cpu_out_type cpuOut,
    input wire logic [7:0] tableAddress,
    input wire logic [7:0] tableData,
    input wire logic [7:0] forcedDataInN,
    input wire logic accShowActiveN,
    input wire logic displayLatchMode,
    input wire logic displayLatchStrobe,
    input wire logic [7:0] displayLamps,
    input wire logic singleCycleReleaseN,
    input wire logic forcedInputGateN,
    input wire logic panelReadyN,
    input wire logic stepCounterClearN,
    input wire logic addressSaveStrobe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Start, stepping, release and display relations
    chk_start_taken: assert property (
        $rose(accShowRequest) && accShowActiveN |=> !stepCounterClearN && addressSaveStrobe)
        else $error("start latch not set by request");
    chk_start_short: assert property (
        $fell(stepCounterClearN) |-> ##[1:70] stepCounterClearN)
        else $error("start latch held too long");
    chk_mode_low: assert property (
        displayLatchMode == accShowActiveN && (stepCounterClearN || !accShowActiveN))
        else $error("display mode not tied to active flag");
    chk_table_page: assert property (
        !accShowActiveN && stepCounterClearN |-> tableAddress[7:4] == 4'h3)
        else $error("table page wrong");
    chk_step_advance: assert property (
        $changed(tableAddress) && !accShowActiveN && !$past(accShowActiveN)
        && $past(stepCounterClearN) |-> tableAddress == $past(tableAddress) + 8'h01)
        else $error("step did not advance by one");
    chk_release_runs: assert property (
        $fell(singleCycleReleaseN) |-> tableAddress[0] && cpuOut.ready && !panelReadyN)
        else $error("release without run on odd step");
    chk_release_window: assert property (
        $fell(singleCycleReleaseN) |-> ##[63:65] $rose(singleCycleReleaseN))
        else $error("release length not one strobe window");
    chk_gate_drives: assert property (
        !forcedInputGateN && cpuIn.dataInStrobe |=> cpuOut.dataInEnable
        && cpuOut.dataIn == ~forcedDataInN && (tableAddress[3] || cpuOut.dataIn == tableData))
        else $error("gated byte not driven");
    chk_sync_clears: assert property (
        cpuOut.ready && cpuIn.cycleSync && !cpuIn.statusDataOut5N |=> !cpuOut.ready)
        else $error("run not cleared by sync");
    chk_port_write: assert property (
        cpuIn.address[7:0] == 8'hFF && cpuIn.outputStatus && cpuIn.writeStrobe
        |=> displayLatchStrobe && displayLamps == $past(cpuIn.dataOut))
        else $error("display latch missed port write");
    chk_output_opcode: assert property (
        !accShowActiveN && tableAddress == 8'h31 |-> tableData == 8'hD3)
        else $error("output opcode missing");
    // Main scenarios reached
    cov_start: cover property ($fell(accShowActiveN));
    cov_port: cover property (displayLatchStrobe);
    cov_end: cover property ($rose(accShowActiveN));
endmodule
bind ads_sequencer ads_sequencer_props #(.TIMER_WIDTH(TIMER_WIDTH)) i_props (
    .clock(clock), .rst_n(rst_n), .accShowRequest(accShowRequest), .cpuIn(cpuIn),
    .cpuOut(cpuOut), .tableAddress(tableAddress), .tableData(tableData),
    .forcedDataInN(forcedDataInN),
    .accShowActiveN(accShowActiveN), .displayLatchMode(displayLatchMode),
    .displayLatchStrobe(displayLatchStrobe), .displayLamps(displayLamps),
    .singleCycleReleaseN(singleCycleReleaseN), .forcedInputGateN(forcedInputGateN),
    .panelReadyN(panelReadyN), .stepCounterClearN(stepCounterClearN),
    .addressSaveStrobe(addressSaveStrobe));
`default_nettype wire

// File: test/ads_cpu_model.sv
// Processor stand-in that waits on ready and runs one cycle per release
`timescale 1ns/1ps
`default_nettype none
module ads_cpu_model #(
    parameter logic [7:0] ACCUMULATOR = 8'h96
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [15:0] programCounter,
    input wire ads_pkg::ads_cpu_out_type cpuOut,
    input wire logic forcedInputGateN,
    output var ads_pkg::ads_cpu_in_type cpuBus
);
    logic [7:0] fetched [0:15];
    int fetchCount;
    logic fetch;
    logic [15:0] pcLine;
    logic [7:0] memLine = 8'h00;
    ads_pkg::ads_cpu_in_type bus;
    // Program counter and memory lines follow the clock
    always @(posedge clock) begin
        pcLine <= programCounter;
        memLine <= memLine + 8'h01;
    end
    // One driver for the bus: cycle lines from the loop, clocked lines merged in
    always_comb begin
        cpuBus = bus;
        cpuBus.programAddress = pcLine;
        cpuBus.memoryData = memLine;
    end
    // Wait state until ready, then one fetch or one output cycle
    initial begin
        fetchCount = 0;
        bus = '0;
        bus.statusDataOut5N = 1'b1;
        bus.dataOut = ~ACCUMULATOR;
        forever begin
            @(posedge clock);
            if (rst_n && cpuOut.ready) begin
                fetch = !forcedInputGateN;
                if (fetch) begin
                    bus.dataInStrobe <= 1'b1;
                end else begin
                    bus.address <= 16'hFFFF;
                    bus.dataOut <= ACCUMULATOR;
                    bus.outputStatus <= 1'b1;
                    bus.writeStrobe <= 1'b1;
                end
                repeat (3) @(posedge clock);
                if (fetch) begin
                    fetched[fetchCount] = cpuOut.dataInEnable ? cpuOut.dataIn : 8'h00;
                    fetchCount++;
                end
                // Released lines show the inverse of what they carried
                bus.dataInStrobe <= 1'b0;
                bus.outputStatus <= 1'b0;
                bus.writeStrobe <= 1'b0;
                bus.address <= 16'h0000;
                bus.dataOut <= ~ACCUMULATOR;
                bus.cycleSync <= 1'b1;
                bus.statusDataOut5N <= 1'b0;
                @(posedge clock);
                bus.cycleSync <= 1'b0;
                bus.statusDataOut5N <= 1'b1;
                @(posedge clock);
            end
        end
    end
endmodule
`default_nettype wire

// File: test/ads_sequencer_bench.sv
// Self-checking bench for the accumulator display sequencer
`timescale 1ns/1ps
`default_nettype none
module ads_sequencer_bench;
    localparam logic [7:0] ACC = 8'h96;
    logic clock;
    logic rst_n;
    logic accShowRequest;
    logic [15:0] programCounter;
    ads_pkg::ads_apb_req_type apbReq;
    ads_pkg::ads_apb_rsp_type apbRsp;
    ads_pkg::ads_cpu_in_type cpuIn;
    ads_pkg::ads_cpu_out_type cpuOut;
    logic [7:0] forcedDataInN;
    logic [7:0] displayLamps;
    logic accShowActiveN;
    logic singleCycleReleaseN;
    logic forcedInputGateN;
    logic panelReadyN;
    logic [31:0] rdata;
    logic err;
    int mismatches;
    int checked;

    ads_sequencer i_dut (.clock(clock), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
        .accShowRequest(accShowRequest), .cpuIn(cpuIn), .cpuOut(cpuOut),
        .forcedDataInN(forcedDataInN), .tableAddress(), .tableData(),
        .accShowActiveN(accShowActiveN), .displayLatchMode(), .displayLatchStrobe(),
        .displayLamps(displayLamps), .singleCycleReleaseN(singleCycleReleaseN),
        .forcedInputGateN(forcedInputGateN), .panelReadyN(panelReadyN),
        .stepCounterClearN(), .addressSaveStrobe());
    ads_cpu_model #(.ACCUMULATOR(ACC)) i_cpu (.clock(clock), .rst_n(rst_n),
        .programCounter(programCounter), .cpuOut(cpuOut),
        .forcedInputGateN(forcedInputGateN), .cpuBus(cpuIn));

    // Compare, report and closing
    task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // One APB transfer, waiting for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int guard;
        @(posedge clock);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge clock);
        apbReq.penable <= 1'b1;
        guard = 0;
        do begin
            @(posedge clock);
            guard++;
        end while (apbRsp.pready !== 1'b1 && guard < 20);
        if (guard >= 20) begin
            check32("pready", 1, 0);
            end_of_test();
        end
        rdata = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask
    // Wait for the active flag to reach a level
    task automatic wait_active(input logic level);
        int guard;
        guard = 0;
        while (accShowActiveN !== level && guard < 20000) begin
            @(posedge clock);
            guard++;
        end
        if (guard >= 20000) begin
            check32("active wait", 1, 0);
            end_of_test();
        end
    endtask
    // Whole display program, started by switch or by register
    task automatic run_program(input logic viaApb, input logic [15:0] pc, input int base);
        programCounter <= pc;
        repeat (3) @(posedge clock);
        if (viaApb) begin
            apb(1'b1, ads_pkg::REG_CONTROL, 32'h0000_0003);
        end else begin
            accShowRequest <= 1'b1;
            repeat (4) @(posedge clock);
            accShowRequest <= 1'b0;
        end
        wait_active(1'b0);
        @(posedge clock);
        programCounter <= ~pc;
        accShowRequest <= 1'b1;
        apb(1'b0, ads_pkg::REG_SAVED_ADDRESS, 32'h0);
        accShowRequest <= 1'b0;
        check32("saved address", {16'h0, pc}, rdata);
        wait_active(1'b1);
        check32("fetch count", base + 5, i_cpu.fetchCount);
        check32("output opcode", 8'hD3, i_cpu.fetched[base]);
        check32("port operand", 8'hFF, i_cpu.fetched[base + 1]);
        check32("jump opcode", 8'hC3, i_cpu.fetched[base + 2]);
        check32("jump low", pc[7:0], i_cpu.fetched[base + 3]);
        check32("jump high", pc[15:8], i_cpu.fetched[base + 4]);
        check32("lamps", ACC, displayLamps);
        apb(1'b0, ads_pkg::REG_LAMPS, 32'h0);
        check32("lamps reg", ACC, rdata);
        apb(1'b0, ads_pkg::REG_STATUS, 32'h0);
        check32("idle phase", 0, rdata & 32'h0000_0007);
    endtask

    // Clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        accShowRequest = 1'b0;
        programCounter = 16'h0000;
        apbReq = '0;
        mismatches = 0;
        checked = 0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        check32("reset lines", 12'hFFF, {forcedDataInN, accShowActiveN,
            singleCycleReleaseN, forcedInputGateN, panelReadyN});
        apb(1'b0, ads_pkg::REG_CONTROL, 32'h0);
        check32("control reset", 32'h0000_0002, rdata);
        apb(1'b1, ads_pkg::REG_CONTROL, 32'h0000_0000);
        apb(1'b0, ads_pkg::REG_CONTROL, 32'h0);
        check32("timer off", 32'h0000_0000, rdata);
        apb(1'b1, ads_pkg::REG_CONTROL, 32'h0000_0002);
        apb(1'b0, ads_pkg::REG_CONTROL, 32'h0);
        check32("timer on", 32'h0000_0002, rdata);
        apb(1'b0, 8'h10, 32'h0);
        check32("unmapped error", 1, err);
        check32("unmapped data", 0, rdata);
        run_program(1'b0, 16'hA5C3, 0);
        run_program(1'b1, 16'h5A3C, 5);
        repeat (1100) @(posedge clock);
        check32("stays idle", {1'b1, 8'd10}, {accShowActiveN, i_cpu.fetchCount[7:0]});
        end_of_test();
    end
endmodule
`default_nettype wire
